// file: lut_slice_pkg.sv
/*
  Shared constants and types of the memory-capable slice: register indices,
  field positions, mode and bus state encodings and reset values.
  Assumes nothing of its surroundings.
*/
package lut_slice_pkg;

  // ----------------------------------------------------------------------
  // Register indices (Avalon word addresses)
  // ----------------------------------------------------------------------
  localparam int         REG_AW     = 3;
  localparam logic [2:0] IDX_CTRL   = 3'h0;
  localparam logic [2:0] IDX_ADDR   = 3'h1;
  localparam logic [2:0] IDX_WDATA  = 3'h2;
  localparam logic [2:0] IDX_RADDR  = 3'h3;
  localparam logic [2:0] IDX_RDATA  = 3'h4;
  localparam logic [2:0] IDX_SHIFT  = 3'h5;
  localparam logic [2:0] IDX_MUXIN  = 3'h6;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_DEPTH_LSB = 4;
  localparam int CTRL_REGRD_BIT = 8;
  localparam int RADDR_B_LSB    = 0;
  localparam int RADDR_C_LSB    = 8;
  localparam int RADDR_D_LSB    = 16;
  localparam int SHIFT_DIN_BIT  = 0;
  localparam int SHIFT_CE_BIT   = 1;
  localparam int RD_MAIN_LSB    = 0;
  localparam int RD_AUX_LSB     = 4;
  localparam int RD_PRI_BIT     = 8;
  localparam int RD_SEC_BIT     = 9;
  localparam int RD_TAIL_BIT    = 10;

  // ----------------------------------------------------------------------
  // Mode codes, depth codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] CODE_SINGLE      = 3'h0;
  localparam logic [2:0] CODE_DUAL        = 3'h1;
  localparam logic [2:0] CODE_QUAD        = 3'h2;
  localparam logic [2:0] CODE_SIMPLE_DUAL = 3'h3;
  localparam logic [2:0] CODE_ROM         = 3'h4;
  localparam logic [2:0] CODE_SHIFT       = 3'h5;
  localparam logic [2:0] CODE_MUX         = 3'h6;
  localparam logic [1:0] DEPTH_32         = 2'h0;
  localparam logic [1:0] DEPTH_64         = 2'h1;
  localparam logic [1:0] DEPTH_128        = 2'h2;
  localparam logic [1:0] DEPTH_256        = 2'h3;
  localparam logic [2:0] RST_MODE_CODE    = 3'h0;
  localparam logic [1:0] RST_DEPTH        = 2'h1;

  typedef enum logic [6:0] {
    MODE_SINGLE      = 7'h01,
    MODE_DUAL        = 7'h02,
    MODE_QUAD        = 7'h04,
    MODE_SIMPLE_DUAL = 7'h08,
    MODE_ROM         = 7'h10,
    MODE_SHIFT       = 7'h20,
    MODE_MUX         = 7'h40
  } mode_t;

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'h1,
    BUS_ANSWER = 2'h2
  } bus_state_t;

endpackage

// file: lut_store.sv
/*
  Storage of the four look-up tables of one slice, 64 bits each, with
  write, shift and asynchronous read paths.
  Assumes one common clock and contents preset by configuration.
*/
`timescale 1ns/1ps
module lut_store #(
  parameter logic [255:0] INIT_CONTENT = 256'h0
) (
  // Clock and reset (reset only quiets the checks)
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Write port
  input  wire logic [3:0]  we_mask,
  input  wire logic [5:0]  wr_addr,
  input  wire logic        pair,
  input  wire logic [3:0]  wd_lo,
  input  wire logic [3:0]  wd_hi,
  // Shift port
  input  wire logic        shift_en,
  input  wire logic        shift_in,
  input  wire logic [1:0]  chain_last,
  // Read ports
  input  wire logic [23:0] rd_addr,
  output logic      [3:0]  lut_main_out,
  output logic      [3:0]  lut_aux_out,
  output logic             cascade_tail_out
);

  typedef struct packed {
    logic [3:0][63:0] lut;
  } store_t;

  store_t store = INIT_CONTENT;
  store_t next_store;

  // ----------------------------------------------------------------------
  // Write and shift
  // ----------------------------------------------------------------------
  always_comb begin
    next_store = store;
    for (int l = 0; l < 4; l++) begin
      if (shift_en && (2'(l) <= chain_last)) begin
        next_store.lut[l][31:0] = {store.lut[l][30:0],
          (2'(l) == chain_last) ? shift_in : store.lut[(l + 1) % 4][31]};
      end else if (we_mask[l]) begin
        if (pair) begin
          next_store.lut[l][{1'b1, wr_addr[4:0]}] = wd_hi[l];
          next_store.lut[l][{1'b0, wr_addr[4:0]}] = wd_lo[l];
        end else begin
          next_store.lut[l][wr_addr] = wd_lo[l];
        end
      end
    end
  end

  // Contents carry no reset at all.
  always_ff @(posedge clk_sys) begin
    store <= next_store;
  end

  // ----------------------------------------------------------------------
  // Asynchronous reads
  // ----------------------------------------------------------------------
  always_comb begin
    for (int l = 0; l < 4; l++) begin
      lut_main_out[l] = store.lut[l][rd_addr[6 * l +: 6]];
      lut_aux_out[l]  = store.lut[l][{1'b0, rd_addr[6 * l +: 5]}];
    end
  end

  assign cascade_tail_out = store.lut[0][31];

  chk_write_lands: assert property (@(posedge clk_sys) disable iff (reset)
    we_mask[0] && !pair && !shift_en |=>
      store.lut[0][$past(wr_addr)] == $past(wd_lo[0]))
    else $error("memory write did not land at its address");

  chk_stage_zero: assert property (@(posedge clk_sys) disable iff (reset)
    shift_en && chain_last == 2'h0 |=> store.lut[0][0] == $past(shift_in))
    else $error("serial input not loaded into stage zero");

  chk_stages_move: assert property (@(posedge clk_sys) disable iff (reset)
    shift_en |=> store.lut[0][31:1] == $past(store.lut[0][30:0]))
    else $error("stages did not move up by one");

  chk_tail_follows: assert property (@(posedge clk_sys) disable iff (reset)
    shift_en ##1 !shift_en |-> cascade_tail_out == $past(store.lut[0][30]))
    else $error("cascade output is not the last stage");

  chk_hold_idle: assert property (@(posedge clk_sys) disable iff (reset)
    !shift_en && we_mask == 4'h0 |=> $stable(store))
    else $error("contents changed without write or shift");

endmodule

// file: lut_slice.sv
/*
  Memory-capable slice: four look-up tables used as distributed memory,
  read-only memory, addressable shift register or wide multiplexer,
  reached over an Avalon-MM slave with waitrequest.
  Assumes one 10 MHz clock, an Avalon master on the same clock.
*/
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
// What this block does
// - Single-port depths 32, 64, 128, 256; dual-port depths 32, 64, 128.
// - Quad-port 32x2 and 64x1; simple dual 32x6 and 64x3, no write-port read.
// - A write stores data at the write address on one clock edge.
// - Single-port: one address selects both write and read location.
// - Dual-port: second table reads its own address, both copies written alike.
// - Quad-port: one read/write port plus three read-only ports.
// - Memory reads are combinational from the applied address.
// - Optional read register adds exactly one cycle of latency.
// - One clock for all tables; shared strobe and address.
// - Depth above 64 combines tables through the wide multiplexers.
// - Read-only memory of 64, 128, 256 bits, contents from configuration.
// - One table is a 32-stage shift register, delay 1 to 32.
// - With enable, serial input enters stage zero; others move up.
// - Output shows the stage picked by the tap address, combinationally.
// - Fixed tap N gives length N plus one.
// - Shift stages have no set or reset.
// - Cascade output carries stage 31, changing after each shift.
// - Four tables chain into up to 128 addressable stages.
// - Only the first table's cascade output leaves the slice.
// - Multiplexers 4:1, 8:1 and 16:1 in one, two, four tables.
// - Writes and shifts are synchronous, gated by an active-high enable.
`timescale 1ns/1ps
module lut_slice #(
  parameter logic [255:0] INIT_CONTENT = 256'h0
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Avalon-MM slave
  input  wire logic [2:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Registered memory outputs
  output logic             primary_read_out,
  output logic             secondary_read_out,
  output logic             cascade_tail_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    lut_slice_pkg::bus_state_t bus;
    logic                      waitrequest;
    logic [31:0]               readdata;
    logic [2:0]                mode_code;
    logic [1:0]                depth;
    logic                      reg_read;
    logic [7:0]                addr;
    logic [5:0]                wdata;
    logic [23:0]               raddr;
    logic [15:0]               muxin;
    logic [1:0]                shift_ctl;
    logic                      primary;
    logic                      secondary;
    logic                      tail;
  } state_t;

  localparam state_t STATE_RESET = '{
    bus:         lut_slice_pkg::BUS_IDLE,
    waitrequest: 1'b1,
    readdata:    32'h0,
    mode_code:   lut_slice_pkg::RST_MODE_CODE,
    depth:       lut_slice_pkg::RST_DEPTH,
    reg_read:    1'b0,
    addr:        8'h00,
    wdata:       6'h00,
    raddr:       24'h000000,
    muxin:       16'h0000,
    shift_ctl:   2'h0,
    primary:     1'b0,
    secondary:   1'b0,
    tail:        1'b0
  };

  state_t state;
  state_t next_state;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Two two-input pair muxes feeding the final two-input mux.
  function automatic logic wide_mux(input logic [3:0] v, input logic [1:0] sel);
    logic wide_mux_lower_pair;
    logic wide_mux_upper_pair;
    wide_mux_lower_pair = sel[0] ? v[1] : v[0];
    wide_mux_upper_pair = sel[0] ? v[3] : v[2];
    return sel[1] ? wide_mux_upper_pair : wide_mux_lower_pair;
  endfunction

  function automatic lut_slice_pkg::mode_t decode_mode(input logic [2:0] code);
    case (code)
      lut_slice_pkg::CODE_SINGLE:      return lut_slice_pkg::MODE_SINGLE;
      lut_slice_pkg::CODE_DUAL:        return lut_slice_pkg::MODE_DUAL;
      lut_slice_pkg::CODE_QUAD:        return lut_slice_pkg::MODE_QUAD;
      lut_slice_pkg::CODE_SIMPLE_DUAL: return lut_slice_pkg::MODE_SIMPLE_DUAL;
      lut_slice_pkg::CODE_ROM:         return lut_slice_pkg::MODE_ROM;
      lut_slice_pkg::CODE_SHIFT:       return lut_slice_pkg::MODE_SHIFT;
      lut_slice_pkg::CODE_MUX:         return lut_slice_pkg::MODE_MUX;
      default:                         return lut_slice_pkg::MODE_SINGLE;
    endcase
  endfunction

  // Depth 32 keeps its bits in the upper half of a table.
  function automatic logic [5:0] table_addr(input logic [5:0] a, input logic [1:0] depth);
    return (depth == lut_slice_pkg::DEPTH_32) ? {1'b1, a[4:0]} : a;
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old_word,
                                           input logic [31:0] new_word,
                                           input logic [3:0]  be);
    logic [31:0] result;
    result = old_word;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        result[8 * b +: 8] = new_word[8 * b +: 8];
      end
    end
    return result;
  endfunction

  // ----------------------------------------------------------------------
  // Slice datapath
  // ----------------------------------------------------------------------
  lut_slice_pkg::mode_t mode;
  logic                 take_write;
  logic                 strobe;
  logic                 shift_fire;
  logic [5:0]           d;
  logic [5:0]           la;
  logic [5:0]           rb;
  logic [1:0]           upper_sel;
  logic [3:0]           we_mask;
  logic                 pair;
  logic [3:0]           wd_lo;
  logic [3:0]           wd_hi;
  logic [23:0]          rd_addr;
  logic                 shift_en;
  logic [3:0]           lut_main_out;
  logic [3:0]           lut_aux_out;
  logic                 tail_c;
  logic                 primary_c;
  logic                 secondary_c;
  logic [3:0]           mux_group;

  assign mode       = decode_mode(state.mode_code);
  assign take_write = write && (state.bus == lut_slice_pkg::BUS_ANSWER);
  assign strobe     = take_write && (address == lut_slice_pkg::IDX_WDATA)
                      && byteenable[0];
  assign shift_fire = take_write && (address == lut_slice_pkg::IDX_SHIFT)
                      && byteenable[0]
                      && writedata[lut_slice_pkg::SHIFT_CE_BIT];
  assign d          = writedata[5:0];
  assign la         = table_addr(state.addr[5:0], state.depth);
  assign rb         = table_addr(state.raddr[lut_slice_pkg::RADDR_B_LSB +: 6], state.depth);

  always_comb begin
    upper_sel = 2'h0;
    if (state.depth == lut_slice_pkg::DEPTH_128) begin
      upper_sel = {1'b0, state.addr[6]};
    end else if (state.depth == lut_slice_pkg::DEPTH_256) begin
      upper_sel = state.addr[7:6];
    end
    for (int l = 0; l < 4; l++) begin
      mux_group[l] = state.muxin[4 * l + 32'(state.addr[1:0])];
    end
  end

  always_comb begin
    we_mask     = 4'h0;
    pair        = 1'b0;
    wd_lo       = {4{d[0]}};
    wd_hi       = {4{d[1]}};
    rd_addr     = {4{la}};
    shift_en    = 1'b0;
    primary_c   = 1'b0;
    secondary_c = 1'b0;
    unique case (mode)
      lut_slice_pkg::MODE_SINGLE, lut_slice_pkg::MODE_ROM: begin
        primary_c = wide_mux(lut_main_out, upper_sel);
        if (mode == lut_slice_pkg::MODE_SINGLE && strobe) begin
          we_mask = 4'h1 << upper_sel;
        end
      end
      lut_slice_pkg::MODE_DUAL: begin
        if (state.depth == lut_slice_pkg::DEPTH_128) begin
          rd_addr     = {rb, rb, la, la};
          primary_c   = wide_mux(lut_main_out, {1'b0, state.addr[6]});
          secondary_c = wide_mux(lut_main_out, {1'b1, state.raddr[6]});
          if (strobe) begin
            we_mask = state.addr[6] ? 4'hA : 4'h5;
          end
        end else begin
          rd_addr     = {la, la, rb, la};
          primary_c   = lut_main_out[0];
          secondary_c = lut_main_out[1];
          if (strobe) begin
            we_mask = 4'h3;
          end
        end
      end
      lut_slice_pkg::MODE_QUAD: begin
        rd_addr = {table_addr(state.raddr[lut_slice_pkg::RADDR_D_LSB +: 6], state.depth),
                   table_addr(state.raddr[lut_slice_pkg::RADDR_C_LSB +: 6], state.depth),
                   rb, la};
        pair        = (state.depth == lut_slice_pkg::DEPTH_32);
        primary_c   = lut_main_out[0];
        secondary_c = lut_main_out[1];
        if (strobe) begin
          we_mask = 4'hF;
        end
      end
      lut_slice_pkg::MODE_SIMPLE_DUAL: begin
        rd_addr     = {la, rb, rb, rb};
        pair        = (state.depth == lut_slice_pkg::DEPTH_32);
        secondary_c = lut_main_out[0];
        if (pair) begin
          wd_lo = {1'b0, d[4], d[2], d[0]};
          wd_hi = {1'b0, d[5], d[3], d[1]};
        end else begin
          wd_lo = {1'b0, d[2:0]};
        end
        if (strobe) begin
          we_mask = 4'h7;
        end
      end
      lut_slice_pkg::MODE_SHIFT: begin
        rd_addr   = {4{1'b0, state.addr[4:0]}};
        shift_en  = shift_fire;
        primary_c = wide_mux(lut_main_out, 2'(state.depth - state.addr[6:5]));
      end
      lut_slice_pkg::MODE_MUX: begin
        if (state.depth == lut_slice_pkg::DEPTH_32) begin
          primary_c = mux_group[0];
        end else if (state.depth == lut_slice_pkg::DEPTH_64) begin
          primary_c = wide_mux(mux_group, {1'b0, state.addr[2]});
        end else begin
          primary_c = wide_mux(mux_group, state.addr[3:2]);
        end
      end
    endcase
  end

  lut_store #(
    .INIT_CONTENT (INIT_CONTENT)
  ) u_store (
    .clk_sys          (clk_sys),
    .reset            (reset),
    .we_mask          (we_mask),
    .wr_addr          (la),
    .pair             (pair),
    .wd_lo            (wd_lo),
    .wd_hi            (wd_hi),
    .shift_en         (shift_en),
    .shift_in         (writedata[lut_slice_pkg::SHIFT_DIN_BIT]),
    .chain_last       (state.depth),
    .rd_addr          (rd_addr),
    .lut_main_out     (lut_main_out),
    .lut_aux_out      (lut_aux_out),
    .cascade_tail_out (tail_c)
  );

  // ----------------------------------------------------------------------
  // Register file and bus answer
  // ----------------------------------------------------------------------
  logic [31:0] ctrl_word;
  logic [31:0] rdata_word;
  logic [31:0] read_value;
  logic [31:0] merged;

  always_comb begin
    ctrl_word = 32'h0;
    ctrl_word[lut_slice_pkg::CTRL_MODE_LSB +: 3]  = state.mode_code;
    ctrl_word[lut_slice_pkg::CTRL_DEPTH_LSB +: 2] = state.depth;
    ctrl_word[lut_slice_pkg::CTRL_REGRD_BIT]      = state.reg_read;
    rdata_word = 32'h0;
    rdata_word[lut_slice_pkg::RD_MAIN_LSB +: 4] = lut_main_out;
    rdata_word[lut_slice_pkg::RD_AUX_LSB +: 4]  = lut_aux_out;
    rdata_word[lut_slice_pkg::RD_PRI_BIT]  = state.reg_read ? state.primary : primary_c;
    rdata_word[lut_slice_pkg::RD_SEC_BIT]  = state.reg_read ? state.secondary : secondary_c;
    rdata_word[lut_slice_pkg::RD_TAIL_BIT] = tail_c;
    unique case (address)
      lut_slice_pkg::IDX_CTRL:  read_value = ctrl_word;
      lut_slice_pkg::IDX_ADDR:  read_value = {24'h0, state.addr};
      lut_slice_pkg::IDX_WDATA: read_value = {26'h0, state.wdata};
      lut_slice_pkg::IDX_RADDR: read_value = {8'h0, state.raddr};
      lut_slice_pkg::IDX_RDATA: read_value = rdata_word;
      lut_slice_pkg::IDX_SHIFT: read_value = {30'h0, state.shift_ctl};
      lut_slice_pkg::IDX_MUXIN: read_value = {16'h0, state.muxin};
      default:                  read_value = 32'h0;
    endcase
  end

  always_comb begin
    next_state           = state;
    next_state.primary   = primary_c;
    next_state.secondary = secondary_c;
    next_state.tail      = tail_c;
    merged               = merge_be(read_value, writedata, byteenable);
    unique case (state.bus)
      lut_slice_pkg::BUS_IDLE: begin
        if (read || write) begin
          next_state.bus         = lut_slice_pkg::BUS_ANSWER;
          next_state.waitrequest = 1'b0;
          next_state.readdata    = read ? read_value : 32'h0;
        end
      end
      lut_slice_pkg::BUS_ANSWER: begin
        next_state.bus         = lut_slice_pkg::BUS_IDLE;
        next_state.waitrequest = 1'b1;
        if (take_write) begin
          unique case (address)
            lut_slice_pkg::IDX_CTRL: begin
              next_state.mode_code = merged[lut_slice_pkg::CTRL_MODE_LSB +: 3];
              next_state.depth     = merged[lut_slice_pkg::CTRL_DEPTH_LSB +: 2];
              next_state.reg_read  = merged[lut_slice_pkg::CTRL_REGRD_BIT];
            end
            lut_slice_pkg::IDX_ADDR:  next_state.addr      = merged[7:0];
            lut_slice_pkg::IDX_WDATA: next_state.wdata     = merged[5:0];
            lut_slice_pkg::IDX_RADDR: next_state.raddr     = merged[23:0];
            lut_slice_pkg::IDX_SHIFT: next_state.shift_ctl = merged[1:0];
            lut_slice_pkg::IDX_MUXIN: next_state.muxin     = merged[15:0];
            default:                  next_state.shift_ctl = state.shift_ctl;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign readdata           = state.readdata;
  assign waitrequest        = state.waitrequest;
  assign primary_read_out   = state.primary;
  assign secondary_read_out = state.secondary;
  assign cascade_tail_out   = state.tail;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_wait_release: assert property (@(posedge clk_sys) disable iff (reset)
    !waitrequest |=> waitrequest)
    else $error("waitrequest stayed low for two cycles");

  chk_wait_answer: assert property (@(posedge clk_sys) disable iff (reset)
    (read || write) && waitrequest && state.bus == lut_slice_pkg::BUS_IDLE |=> !waitrequest)
    else $error("request not answered in one cycle");

  chk_read_latency: assert property (@(posedge clk_sys) disable iff (reset)
    !reset |=> primary_read_out == $past(primary_c))
    else $error("registered read is not one cycle behind");

  chk_simple_dual_quiet: assert property (@(posedge clk_sys) disable iff (reset)
    mode == lut_slice_pkg::MODE_SIMPLE_DUAL |=> !primary_read_out)
    else $error("simple dual write port produced read data");

  chk_rom_no_write: assert property (@(posedge clk_sys) disable iff (reset)
    mode == lut_slice_pkg::MODE_ROM |-> we_mask == 4'h0)
    else $error("read-only memory was written");

  chk_dual_copies: assert property (@(posedge clk_sys) disable iff (reset)
    mode == lut_slice_pkg::MODE_DUAL && strobe |-> $countones(we_mask) == 2)
    else $error("dual-port copies not written together");

endmodule

// file: user_logic_model.sv
/*
  Model of the fabric user logic: an Avalon-MM master that reaches the slice.
  Assumes the slice answers on the same clock with waitrequest.
*/
`timescale 1ns/1ps
module user_logic_model (
  // Avalon-MM master side
  input  wire logic        clk_sys,
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  output logic      [2:0]  address,
  output logic             read,
  output logic             write,
  output logic      [3:0]  byteenable,
  output logic      [31:0] writedata
);
  initial begin
    address = 3'h0;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'hF;
    writedata = 32'h0;
  end

  // The request stands until waitrequest is seen low at a rising edge.
  task automatic xfer(input logic w, input logic [2:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_sys);
    read <= ~w;
    write <= w;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clk_sys);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule

// file: tb.sv
/*
  Self-checking bench of the slice: memory modes and the shift chain.
  Assumes contents start from the bench's own configuration pattern.
*/
`timescale 1ns/1ps
module tb;
  logic        clk_sys;
  logic        reset;
  logic [2:0]  address;
  logic        read;
  logic        write;
  logic [3:0]  byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        primary_read_out;
  logic        secondary_read_out;
  logic        cascade_tail_out;
  logic [31:0] q;
  int          mismatches;
  int          tests_run;
  logic [31:0] ctl[15] = '{32'h14, 32'h34, 32'h00, 32'h10, 32'h20, 32'h30, 32'h01, 32'h11,
                           32'h21, 32'h02, 32'h12, 32'h03, 32'h13, 32'h110, 32'h121};
  // Arbitrary test pattern preloaded as configuration contents.
  localparam logic [255:0] ROM_INIT = {8{32'h96C3A51E}};

  lut_slice #(.INIT_CONTENT(ROM_INIT)) i_dut (.clk_sys, .reset, .address, .read, .write,
    .byteenable, .writedata,
    .readdata, .waitrequest, .primary_read_out, .secondary_read_out, .cascade_tail_out);
  user_logic_model i_user (.clk_sys, .waitrequest, .readdata, .address, .read, .write,
    .byteenable, .writedata);

  task automatic check(input string what, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    i_user.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_bit(input string what, input int b, input logic e);
    i_user.xfer(1'b0, lut_slice_pkg::IDX_RDATA, 32'h0, q);
    check(what, e, q[b]);
  endtask
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic mem_test(input logic [31:0] ctrl);
    logic mem[int];
    int   a;
    int   p;
    logic d;
    logic rom;
    logic simple_dual_mode;
    p   = -1;
    rom = (ctrl[2:0] == 3'h4);
    simple_dual_mode = (ctrl[2:0] == 3'h3);
    wr(lut_slice_pkg::IDX_CTRL, ctrl);
    repeat (12) begin
      a = $urandom_range((32 << ctrl[5:4]) - 1);
      d = 1'($urandom_range(1));
      wr(lut_slice_pkg::IDX_ADDR, 32'(a));
      if (mem.exists(a)) rd_bit("old data", lut_slice_pkg::RD_PRI_BIT, mem[a] & !simple_dual_mode);
      wr(lut_slice_pkg::IDX_WDATA, {26'h0, {6{d}}});
      mem[a] = rom ? ROM_INIT[a] : d;
      rd_bit("read back", lut_slice_pkg::RD_PRI_BIT, mem[a] & !simple_dual_mode);
      check("read flop", mem[a] & !simple_dual_mode, primary_read_out);
      if (!ctrl[2] && ctrl[1:0] != 2'h0 && p >= 0) begin
        wr(lut_slice_pkg::IDX_RADDR, 32'(p) * 32'h10101);
        rd_bit("second port", lut_slice_pkg::RD_SEC_BIT, mem[p]);
        check("second flop", mem[p], secondary_read_out);
        if (ctrl[1:0] == 2'h2) check("port D", mem[p], q[3]);
      end
      p = a;
    end
  endtask

  task automatic shift_test(input logic [31:0] ctrl, input int len);
    logic sr[$];
    logic b;
    logic ce;
    int   n;
    wr(lut_slice_pkg::IDX_CTRL, ctrl);
    for (int i = 0; i < len + 24; i++) begin
      b = 1'($urandom_range(1));
      ce = (i < len) || ($urandom_range(3) != 0);
      wr(lut_slice_pkg::IDX_SHIFT, {30'h0, ce, b});
      if (ce) sr.push_front(b);
      if (sr.size() > len) void'(sr.pop_back());
      if (i == len) begin
        reset <= 1'b1;
        @(posedge clk_sys);
        reset <= 1'b0;
        wr(lut_slice_pkg::IDX_CTRL, ctrl);
      end
      if (i >= len) begin
        n = $urandom_range(len - 1);
        wr(lut_slice_pkg::IDX_ADDR, 32'(n));
        rd_bit("tap stage", lut_slice_pkg::RD_PRI_BIT, sr[n]);
        check("tail bit", sr[len - 1], q[lut_slice_pkg::RD_TAIL_BIT]);
        check("tail port", sr[len - 1], cascade_tail_out);
      end
    end
  endtask

  task automatic mux_test(input int dep);
    logic [15:0] v;
    int          s;
    wr(lut_slice_pkg::IDX_CTRL, 32'(6 + 16 * dep));
    repeat (8) begin
      v = 16'($urandom);
      s = $urandom_range(15);
      wr(lut_slice_pkg::IDX_MUXIN, {16'h0, v});
      wr(lut_slice_pkg::IDX_ADDR, 32'(s));
      rd_bit("mux out", lut_slice_pkg::RD_PRI_BIT, v[s & ((4 << dep) - 1)]);
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end
  initial begin
    reset = 1'b1;
    mismatches = 0;
    tests_run = 0;
    void'($urandom(32'h478C9345));
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (ctl[i]) mem_test(ctl[i]);
    shift_test(32'h05, 32);
    shift_test(32'h35, 128);
    for (int k = 0; k < 3; k++) mux_test(k);
    wrap_up();
  end
endmodule
